// ==== src/sdcp_pin_ctrl.sv ====
// SDRAM clock pin control: clock gating and pin hand-over to port
`timescale 1ns/100ps
`include "sdcp_defines.svh"
module sdcp_pin_ctrl #(
   parameter bit HAS_SDRAM = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sdram_clock_stop,
   input wire logic port_dir,
   input wire logic port_data,
   input wire logic bus_busy,
   input wire sdcp_pkg::sdcp_proc_e proc_state,
   output logic pin_out,
   output logic pin_oe,
   output logic clock_active
);
   import sdcp_pkg::*;

   // Registered pin state; every output leaves straight from here
   typedef struct packed {
      logic pin_out;
      logic pin_oe;
      logic active;
   } sdcp_pin_s;
   sdcp_pin_s q;
   sdcp_pin_s next_q;
   sdcp_gate_if gate_bus();
   logic stop_eff;
   logic clock_owned;

   // Hardware standby floats the pin whatever else is set
   function automatic logic sdcp_floats(input sdcp_proc_e ps);
      return ps == SDCP_HW_STANDBY;
   endfunction : sdcp_floats

   // Software standby parks a running clock low rather than freezing it
   // mid-pulse, so the memory never sees a half-width high phase
   function automatic logic sdcp_parks_low(input sdcp_proc_e ps);
      return ps == SDCP_SW_STANDBY;
   endfunction : sdcp_parks_low

   // Without the SDRAM interface the stop bit is forced on
   assign stop_eff = HAS_SDRAM ? sdram_clock_stop : 1'b1;

   // The gate still winds down after reset even in a variant without the
   // interface; masking here keeps that short run off the pin entirely
   assign clock_owned = HAS_SDRAM && gate_bus.clk_run;

   // Clock generator and cycle-boundary stop
   sdcp_clkgen u_clkgen (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .stop_req(stop_eff),
      .bus_busy(bus_busy),
      .gate(gate_bus.ctrl)
   );

   // Pin mux per processing state. Summary of what the pin carries:
   //   clock owned, normal, sleep or all-stop : divided clock
   //   clock owned, software standby          : driven low
   //   released, direction output             : port data
   //   released, direction input              : floating
   //   hardware standby, any setting          : floating
   // The mux is registered, so a change of state or direction reaches the
   // pin one cycle late; the trade buys glitch-free pin timing.
   always_comb begin
      next_q.active = clock_owned;
      next_q.pin_out = 1'b0;
      next_q.pin_oe = 1'b0;
      if (sdcp_floats(proc_state)) begin
         next_q.pin_oe = 1'b0;
      end else if (clock_owned) begin
         // Clock owns the pin regardless of direction
         if (sdcp_parks_low(proc_state)) begin
            next_q.pin_oe = 1'b1;
            next_q.pin_out = 1'b0;
         end else begin
            next_q.pin_oe = 1'b1;
            next_q.pin_out = gate_bus.clk_level;
         end
      end else begin
         // Released pin follows the port direction
         next_q.pin_oe = port_dir;
         next_q.pin_out = port_dir & port_data;
      end
   end

   // State register; reset leaves the pin floating and the clock off
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign pin_out = q.pin_out;
   assign pin_oe = q.pin_oe;
   assign clock_active = q.active;

   // Sequences shared by the pin assertions. The first two describe who owns the
   // pin in the cycle they match; the registered mux shows the result one
   // cycle later, hence the non-overlapping implications below.
   sequence s_clock_owned;
      clock_owned && !sdcp_floats(proc_state) && !sdcp_parks_low(proc_state);
   endsequence
   sequence s_released;
      !clock_owned && !sdcp_floats(proc_state);
   endsequence
   sequence s_stop_idle;
      stop_eff && !bus_busy;
   endsequence

   // Hardware standby always floats the pin
   a_hw_standby_float: assert property (@(posedge core_clk) disable iff (!rst_n)
      sdcp_floats(proc_state) |=> !pin_oe)
      else $error("pin driven in hardware standby");

   // Once released, the direction bit alone decides the driver
   a_port_handover: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_released |=> (pin_oe == $past(port_dir)))
      else $error("released pin ignores direction");

   // Released output pin carries the port data
   a_port_level: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_released |=> (pin_out == ($past(port_dir) && $past(port_data))))
      else $error("released pin shows wrong level");

   // Released input pin floats in every state
   a_input_floats: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!clock_owned && !port_dir) |=> !pin_oe)
      else $error("input pin driven");

   // Outside hardware standby, a running clock is driven whatever the direction bit says
   a_clock_drives: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clock_owned && !sdcp_floats(proc_state)) |=> pin_oe)
      else $error("clock not driven");

   // Two owned cycles in a row must show a level change on the pin
   a_clock_toggles: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_clock_owned ##1 s_clock_owned |=> (pin_out != $past(pin_out)))
      else $error("clock stuck on pin");

   // Software standby parks the running clock low
   a_sw_parks_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clock_owned && sdcp_parks_low(proc_state)) |=> (pin_oe && !pin_out))
      else $error("clock not parked low in software standby");

   // Without the interface the clock never shows as active
   a_no_sdram_port: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!HAS_SDRAM) |-> ##3 !clock_active)
      else $error("clock runs without SDRAM interface");

   // Activity flag follows ownership one cycle late
   a_active_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (clock_active == $past(clock_owned)))
      else $error("activity flag out of step");

   // With the bus idle, a stop request lands within three cycles
   a_stop_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_stop_idle [*3] |=> !gate_bus.clk_run)
      else $error("clock stop never landed");

   // Clearing the stop bit restarts the clock on the next edge
   a_stop_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!gate_bus.clk_run && !stop_eff) |=> gate_bus.clk_run)
      else $error("clock did not restart");

   // Reset leaves the pin floating and the clock flag low
   a_reset_quiet: assert property (@(posedge core_clk)
      !rst_n |=> (!pin_oe && !pin_out && !clock_active))
      else $error("pin not quiet after reset");
endmodule : sdcp_pin_ctrl

// ==== src/sdcp_defines.svh ====
// Constants for the SDRAM clock pin control block
`ifndef SDCP_DEFINES_SVH
`define SDCP_DEFINES_SVH
`define SDCP_STOP_RESET 1'b0
`define SDCP_DIV_RESET 1'b0
`endif

// ==== src/sdcp_pkg.sv ====
// Types for the SDRAM clock pin control block
package sdcp_pkg;
   // Chip processing states
   typedef enum logic [2:0] {
      SDCP_NORMAL = 3'h0,
      SDCP_SLEEP = 3'h1,
      SDCP_ALL_STOP = 3'h3,
      SDCP_SW_STANDBY = 3'h2,
      SDCP_HW_STANDBY = 3'h6
   } sdcp_proc_e;
   // Clock gate states
   typedef enum logic [1:0] {
      SDCP_RUN = 2'h0,
      SDCP_WAIT_END = 2'h1,
      SDCP_STOPPED = 2'h3
   } sdcp_gate_e;
endpackage : sdcp_pkg

// ==== src/sdcp_gate_if.sv ====
// Signals between the gate controller and the pin mux
`timescale 1ns/100ps
interface sdcp_gate_if;
   logic clk_run;
   logic clk_level;
   modport ctrl (output clk_run, output clk_level);
   modport pin (input clk_run, input clk_level);
endinterface : sdcp_gate_if

// ==== src/sdcp_clkgen.sv ====
// Divided SDRAM clock generator with cycle-boundary stop
`timescale 1ns/100ps
`include "sdcp_defines.svh"
module sdcp_clkgen (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic stop_req,
   input wire logic bus_busy,
   sdcp_gate_if.ctrl gate
);
   import sdcp_pkg::*;
   typedef struct packed {
      sdcp_gate_e st;
      logic level;
   } sdcp_cg_s;
   sdcp_cg_s q;
   sdcp_cg_s next_q;
   // Stop only when no bus cycle is in flight and clock is low, so no runt pulse
   always_comb begin
      next_q = q;
      case (q.st)
         SDCP_RUN: begin
            next_q.level = ~q.level;
            if (stop_req) begin
               next_q.st = SDCP_WAIT_END;
            end
         end
         SDCP_WAIT_END: begin
            next_q.level = ~q.level;
            if (!stop_req) begin
               next_q.st = SDCP_RUN;
            end else if (!bus_busy && !q.level) begin
               next_q.st = SDCP_STOPPED;
               next_q.level = 1'b0;
            end
         end
         SDCP_STOPPED: begin
            next_q.level = 1'b0;
            if (!stop_req) begin
               next_q.st = SDCP_RUN;
            end
         end
         default: begin
            next_q.st = SDCP_RUN;
            next_q.level = 1'b0;
         end
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q.st <= SDCP_RUN;
         q.level <= `SDCP_DIV_RESET;
      end else begin
         q <= next_q;
      end
   end
   assign gate.clk_run = (q.st != SDCP_STOPPED);
   assign gate.clk_level = q.level;
   // Stop never lands during a bus cycle
   a_stop_after_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.st == SDCP_WAIT_END && bus_busy) |=> (q.st != SDCP_STOPPED))
      else $error("clock stopped during bus cycle");
endmodule : sdcp_clkgen

// ==== test/sdcp_sdram_model.sv ====
// Memory side model: counts the rising clock edges it receives
`timescale 1ns/100ps
module sdcp_sdram_model (
   input wire logic sd_clk,
   input wire logic sd_en,
   output int edges
);
   // Only a driven pin clocks the memory; a floating pin is ignored
   initial edges = 0;
   always @(posedge sd_clk) if (sd_en) edges <= edges + 1;
endmodule : sdcp_sdram_model

// ==== test/test_sdcp_pin_ctrl.sv ====
// Self-checking bench for the SDRAM clock pin control
`timescale 1ns/100ps
module test_sdcp_pin_ctrl;
   import sdcp_pkg::*;
   `define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %b", $time, a); end end
   logic core_clk = 0, rst_n = 0, stop = 0, dir = 0, dat = 0, busy = 0, tog;
   sdcp_proc_e st = SDCP_NORMAL;
   sdcp_proc_e states[5] = '{SDCP_NORMAL, SDCP_SLEEP, SDCP_ALL_STOP, SDCP_SW_STANDBY, SDCP_HW_STANDBY};
   logic pin_out, pin_oe, clock_active, n_out, n_oe, n_act;
   int edges, e0, errors = 0, checked = 0, cyc = 0;
   logic [7:0] lf = 8'h12;
   logic [3:0] q[$];
   event look;
   sdcp_pin_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .sdram_clock_stop(stop), .port_dir(dir),
      .port_data(dat), .bus_busy(busy), .proc_state(st), .pin_out(pin_out), .pin_oe(pin_oe),
      .clock_active(clock_active));
   // Variant without the SDRAM interface: pin is always a port
   sdcp_pin_ctrl #(.HAS_SDRAM(1'b0)) u_dut_nosd (.core_clk(core_clk), .rst_n(rst_n), .sdram_clock_stop(stop),
      .port_dir(dir), .port_data(dat), .bus_busy(busy), .proc_state(st), .pin_out(n_out), .pin_oe(n_oe),
      .clock_active(n_act));
   sdcp_sdram_model u_mem (.sd_clk(pin_out), .sd_en(pin_oe), .edges(edges));
   // 250 MHz clock
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [7:0] lfsr(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   // Expected {active, enable, clocking, level}
   function automatic logic [3:0] want();
      if (st == SDCP_HW_STANDBY) return {!stop, 3'h0};
      if (!stop) return (st == SDCP_SW_STANDBY) ? 4'hc : 4'he;
      return dir ? {3'b010, dat} : 4'h0;
   endfunction : want
   task test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Settle, note the expectation, hold inputs while the monitor looks
   task step(int n, logic [3:0] w);
      repeat (n) @(negedge core_clk);
      q.push_back(w);
      ->look;
      repeat (3) @(negedge core_clk);
   endtask : step
   // Two core cycles hold exactly one rising edge of a running clock
   initial begin
      forever begin
         @look;
         e0 = edges;
         repeat (2) @(posedge core_clk);
         #1 tog = edges != e0;
         `CHK({clock_active, pin_oe, tog, tog ? 1'b0 : pin_out}, q.pop_front())
         `CHK({n_act, n_oe, n_out}, {1'b0, dir && st != SDCP_HW_STANDBY, dir && dat && st != SDCP_HW_STANDBY})
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1500) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(negedge core_clk);
      rst_n = 1;
      step(4, want());
      stop = 1;
      busy = 1;
      step(6, 4'he);
      busy = 0;
      step(6, want());
      // Random stop, direction, data and state
      for (int i = 0; i < 40; i++) begin
         lf = lfsr(lf);
         {stop, dir, dat} = lf[2:0];
         st = states[lf[7:5] % 5];
         step(6, want());
      end
      test_done();
   end
endmodule : test_sdcp_pin_ctrl
